// File: shared/rx_address_filter_params.svh
`ifndef RX_ADDRESS_FILTER_PARAMS_SVH
`define RX_ADDRESS_FILTER_PARAMS_SVH

// Register byte offsets on the Avalon-MM slave.
`define OFS_RECEIVE_CONTROL   5'h00
`define OFS_STATION_ADDR_LOW  5'h04
`define OFS_STATION_ADDR_HIGH 5'h08
`define OFS_GROUP_HASH_UPPER  5'h0C
`define OFS_GROUP_HASH_LOWER  5'h10
`define OFS_UNICAST_HASH_UPPER 5'h14
`define OFS_UNICAST_HASH_LOWER 5'h18
`define OFS_FILTER_STATUS     5'h1C

// Field positions in receive_control_reg.
`define BIT_BROADCAST_REJECT    0
`define BIT_PROMISCUOUS_ACCEPT  1
`define BIT_FLOW_CONTROL_ENABLE 2
`define RECEIVE_CONTROL_RESET   3'h0
`define REG_RESET               32'h0000_0000

// Frame layout, in byte positions counted from the first destination byte.
`define ADDR_BYTES    7'h06
`define TYPE_POS      7'h0C
`define OPCODE_END    7'h0F
`define ACCEPT_BYTES  7'h40

// Reserved control frame address, type and opcode, and the broadcast address.
`define PAUSE_ADDR     48'h0180_C200_0001
`define PAUSE_TYPE_OP  32'h8808_0001
`define BROADCAST_ADDR 48'hFFFF_FFFF_FFFF

// Hash generator.
`define CRC_POLY      32'h04C1_1DB7
`define CRC_PRESET    32'hFFFF_FFFF

`endif

// File: shared/rx_filter_pkg.sv
package rx_filter_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_HOLD,
        ST_TAIL
    } filter_state_e;

    typedef logic [47:0] mac_addr_t;
    typedef logic [5:0]  hash_index_t;

endpackage

// File: core/hash_crc.sv
`include "rx_address_filter_params.svh"

// Byte-wide CRC, bits taken least significant first.
module hash_crc #(
    parameter int          WIDTH = 32,
    parameter logic [31:0] POLY  = `CRC_POLY
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             preset,
    input  wire logic             feed,
    input  wire logic [7:0]       data,
    output logic      [WIDTH-1:0] crc
);

    logic [WIDTH-1:0] crc_ff;
    logic [WIDTH-1:0] nxt_crc;
    logic [WIDTH-1:0] base;

    // A preset in the same cycle as a feed starts from all ones, so the first byte is not lost.
    always_comb begin
        base = preset ? WIDTH'(`CRC_PRESET) : crc_ff;
        nxt_crc = base;
        if (feed) begin
            for (int i = 0; i < 8; i++) begin
                if (nxt_crc[WIDTH-1] ^ data[i]) begin
                    nxt_crc = {nxt_crc[WIDTH-2:0], 1'b0} ^ POLY[WIDTH-1:0];
                end else begin
                    nxt_crc = {nxt_crc[WIDTH-2:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            crc_ff <= WIDTH'(`CRC_PRESET);
        end else begin
            crc_ff <= nxt_crc;
        end
    end

    assign crc = crc_ff;

endmodule

// File: core/rx_address_filter.sv
// The register addresses and the Avalon-MM register port were left to the implementer.
`include "rx_address_filter_params.svh"

module rx_address_filter #(
    parameter int CNT_W = 7
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_sof,
    input  wire logic        rx_eof,
    output logic             fifo_accept,
    output logic             fifo_reject,
    output logic             frame_miss,
    output logic             frame_broadcast,
    output logic             frame_multicast,
    output logic             pause_detected
);
    import rx_filter_pkg::*;

    logic [2:0]               receive_control_reg_ff;
    logic [31:0]              station_addr_low_ff;
    logic [31:0]              station_addr_high_ff;
    logic [31:0]              group_hash_upper_ff;
    logic [31:0]              group_hash_lower_ff;
    logic [31:0]              unicast_hash_upper_ff;
    logic [31:0]              unicast_hash_lower_ff;
    logic [31:0]              readdata_ff;
    logic                     waitrequest_ff;
    logic                     bus_req;
    logic                     bus_wr;
    logic [31:0]              nxt_readdata;

    filter_state_e            state_ff;
    logic [CNT_W-1:0]         cnt_ff;
    logic [CNT_W-1:0]         byte_idx;
    mac_addr_t                destination_address_ff;
    logic [31:0]              type_op_ff;
    logic                     frame_end_ff;
    logic                     pause_cand_ff;
    hash_index_t              hash_idx_ff;
    logic                     fifo_accept_ff;
    logic                     fifo_reject_ff;
    logic                     frame_miss_ff;
    logic                     frame_broadcast_ff;
    logic                     frame_multicast_ff;
    logic                     pause_detected_ff;

    logic [31:0]              crc;
    logic                     crc_feed;
    logic                     broadcast_reject;
    logic                     promiscuous_accept;
    logic                     flow_control_enable;
    mac_addr_t                station_addr;
    hash_index_t              hash_idx;
    logic [31:0]              group_word;
    logic [31:0]              unicast_word;
    logic                     is_broadcast;
    logic                     is_group;
    logic                     is_pause_addr;
    logic                     is_station;
    logic                     addr_match;
    logic                     addr_ok;
    logic                     pause_cand;
    logic                     decide_addr;
    logic                     decide_accept;
    logic                     runt;

    // Avalon-MM slave: every access takes exactly one wait cycle.
    // The fixed latency means the slave keeps no request state beyond one flag.
    // Read data is registered in the wait cycle and stands until the next read.
    assign bus_req = avs_read | avs_write;
    assign bus_wr  = avs_write & ~waitrequest_ff;

    always_ff @(posedge mclk) begin
        if (rst) begin
            waitrequest_ff <= 1'b1;
        end else begin
            waitrequest_ff <= ~(bus_req & waitrequest_ff);
        end
    end

    always_comb begin
        nxt_readdata = 32'h0000_0000;
        unique case (avs_address)
            `OFS_RECEIVE_CONTROL:    nxt_readdata = {29'h0000_0000, receive_control_reg_ff};
            `OFS_STATION_ADDR_LOW:   nxt_readdata = station_addr_low_ff;
            `OFS_STATION_ADDR_HIGH:  nxt_readdata = station_addr_high_ff;
            `OFS_GROUP_HASH_UPPER:   nxt_readdata = group_hash_upper_ff;
            `OFS_GROUP_HASH_LOWER:   nxt_readdata = group_hash_lower_ff;
            `OFS_UNICAST_HASH_UPPER: nxt_readdata = unicast_hash_upper_ff;
            `OFS_UNICAST_HASH_LOWER: nxt_readdata = unicast_hash_lower_ff;
            `OFS_FILTER_STATUS:      nxt_readdata = {20'h0_0000, state_ff, pause_cand_ff, frame_miss_ff,
                                                     frame_broadcast_ff, frame_multicast_ff, hash_idx_ff};
            default:                 nxt_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            readdata_ff <= `REG_RESET;
        end else if (avs_read & waitrequest_ff) begin
            readdata_ff <= nxt_readdata;
        end
    end

    // The tables reset to zero, but software still has to load them before hash filtering means anything.
    always_ff @(posedge mclk) begin
        if (rst) begin
            receive_control_reg_ff <= `RECEIVE_CONTROL_RESET;
            station_addr_low_ff    <= `REG_RESET;
            station_addr_high_ff   <= `REG_RESET;
            group_hash_upper_ff    <= `REG_RESET;
            group_hash_lower_ff    <= `REG_RESET;
            unicast_hash_upper_ff  <= `REG_RESET;
            unicast_hash_lower_ff  <= `REG_RESET;
        end else if (bus_wr) begin
            unique case (avs_address)
                `OFS_RECEIVE_CONTROL:    receive_control_reg_ff <= avs_writedata[2:0];
                `OFS_STATION_ADDR_LOW:   station_addr_low_ff    <= avs_writedata;
                `OFS_STATION_ADDR_HIGH:  station_addr_high_ff   <= {avs_writedata[31:16], 16'h0000};
                `OFS_GROUP_HASH_UPPER:   group_hash_upper_ff    <= avs_writedata;
                `OFS_GROUP_HASH_LOWER:   group_hash_lower_ff    <= avs_writedata;
                `OFS_UNICAST_HASH_UPPER: unicast_hash_upper_ff  <= avs_writedata;
                `OFS_UNICAST_HASH_LOWER: unicast_hash_lower_ff  <= avs_writedata;
                default: ;
            endcase
        end
    end

    assign broadcast_reject    = receive_control_reg_ff[`BIT_BROADCAST_REJECT];
    assign promiscuous_accept  = receive_control_reg_ff[`BIT_PROMISCUOUS_ACCEPT];
    assign flow_control_enable = receive_control_reg_ff[`BIT_FLOW_CONTROL_ENABLE];
    assign station_addr        = {station_addr_low_ff, station_addr_high_ff[31:16]};

    // Byte intake: the counter restarts on every start of frame and saturates.
    // Saturation keeps a giant frame from wrapping back onto a decision point.
    // Address and type/opcode bytes are captured by their byte position.
    assign byte_idx = rx_sof ? '0 : cnt_ff;
    assign crc_feed = rx_valid & (byte_idx < `ADDR_BYTES);

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (rx_valid) begin
            if (rx_sof) begin
                cnt_ff <= CNT_W'(1);
            end else if (~&cnt_ff) begin
                cnt_ff <= cnt_ff + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            destination_address_ff <= '0;
        end else if (crc_feed) begin
            destination_address_ff <= {destination_address_ff[39:0], rx_data};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            type_op_ff <= 32'h0000_0000;
        end else if (rx_valid && byte_idx >= `TYPE_POS && byte_idx <= `OPCODE_END) begin
            type_op_ff <= {type_op_ff[23:0], rx_data};
        end
    end

    // The end mark is held so that a frame shorter than a decision point is still seen as ended.
    always_ff @(posedge mclk) begin
        if (rst) begin
            frame_end_ff <= 1'b0;
        end else if (rx_valid) begin
            frame_end_ff <= rx_eof;
        end
    end

    hash_crc #(
        .WIDTH (32),
        .POLY  (`CRC_POLY)
    ) u_hash_crc (
        .mclk   (mclk),
        .rst    (rst),
        .preset (rx_valid & rx_sof),
        .feed   (crc_feed),
        .data   (rx_data),
        .crc    (crc)
    );

    // Address recognition works only on the registered address bytes and the settled CRC.
    // Classification and hash lookup are combinational from those registers.
    // The outcome is latched once per frame, at the address decision.
    assign hash_idx     = crc[31:26];
    assign group_word   = hash_idx[5] ? group_hash_upper_ff : group_hash_lower_ff;
    assign unicast_word = hash_idx[5] ? unicast_hash_upper_ff : unicast_hash_lower_ff;
    assign is_broadcast = destination_address_ff == `BROADCAST_ADDR;
    assign is_group     = destination_address_ff[40];
    assign is_pause_addr = destination_address_ff == `PAUSE_ADDR;
    assign is_station   = destination_address_ff == station_addr;

    always_comb begin
        addr_match = 1'b0;
        pause_cand = 1'b0;
        if (is_broadcast) begin
            addr_match = ~broadcast_reject;
        end else if (is_group) begin
            if (flow_control_enable) begin
                addr_match = is_pause_addr;
                pause_cand = is_pause_addr;
            end else begin
                addr_match = group_word[hash_idx[4:0]];
            end
        end else begin
            addr_match = is_station | unicast_word[hash_idx[4:0]];
            pause_cand = flow_control_enable & is_station;
        end
        addr_ok = addr_match | promiscuous_accept;
    end

    // Recognition waits one cycle after the sixth byte so the CRC register holds the full address.
    assign decide_addr   = (state_ff == ST_ADDR) && (cnt_ff >= `ADDR_BYTES);
    assign decide_accept = (state_ff == ST_HOLD) && (cnt_ff >= `ACCEPT_BYTES);
    assign runt          = frame_end_ff && ((state_ff == ST_ADDR && cnt_ff < `ADDR_BYTES) ||
                                            (state_ff == ST_HOLD && cnt_ff < `ACCEPT_BYTES));

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else if (rx_valid & rx_sof) begin
            state_ff <= ST_ADDR;
        end else begin
            unique case (state_ff)
                ST_IDLE: ;
                ST_ADDR: begin
                    if (runt) begin
                        state_ff <= ST_IDLE;
                    end else if (decide_addr) begin
                        state_ff <= addr_ok ? ST_HOLD : ST_TAIL;
                    end
                end
                ST_HOLD: begin
                    if (runt) begin
                        state_ff <= ST_IDLE;
                    end else if (decide_accept) begin
                        state_ff <= ST_TAIL;
                    end
                end
                ST_TAIL: begin
                    if (frame_end_ff) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pause_cand_ff      <= 1'b0;
            hash_idx_ff        <= '0;
            frame_miss_ff      <= 1'b0;
            frame_broadcast_ff <= 1'b0;
            frame_multicast_ff <= 1'b0;
        end else if (decide_addr && !runt) begin
            pause_cand_ff      <= pause_cand;
            hash_idx_ff        <= hash_idx;
            frame_miss_ff      <= addr_ok & ~addr_match;
            frame_broadcast_ff <= is_broadcast;
            frame_multicast_ff <= is_group & ~is_broadcast;
        end
    end

    // Accept and reject are one-cycle pulses to the receive FIFO; a runt is flushed like an address miss.
    always_ff @(posedge mclk) begin
        if (rst) begin
            fifo_accept_ff    <= 1'b0;
            fifo_reject_ff    <= 1'b0;
            pause_detected_ff <= 1'b0;
        end else begin
            fifo_accept_ff    <= 1'b0;
            fifo_reject_ff    <= 1'b0;
            pause_detected_ff <= 1'b0;
            if (runt) begin
                fifo_reject_ff <= 1'b1;
            end else if (decide_addr && !addr_ok) begin
                fifo_reject_ff <= 1'b1;
            end else if (decide_accept) begin
                if (pause_cand_ff && type_op_ff == `PAUSE_TYPE_OP) begin
                    fifo_reject_ff    <= 1'b1;
                    pause_detected_ff <= 1'b1;
                end else begin
                    fifo_accept_ff <= 1'b1;
                end
            end
        end
    end

    assign avs_readdata    = readdata_ff;
    assign avs_waitrequest = waitrequest_ff;
    assign fifo_accept     = fifo_accept_ff;
    assign fifo_reject     = fifo_reject_ff;
    assign frame_miss      = frame_miss_ff;
    assign frame_broadcast = frame_broadcast_ff;
    assign frame_multicast = frame_multicast_ff;
    assign pause_detected  = pause_detected_ff;

endmodule

// File: verification/rx_address_filter_assertions.sv
`include "rx_address_filter_params.svh"

module rx_address_filter_assertions #(
    parameter int CNT_W = 7
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_data,
    input wire logic        rx_sof,
    input wire logic        rx_eof,
    input wire logic        fifo_accept,
    input wire logic        fifo_reject,
    input wire logic        frame_miss,
    input wire logic        frame_broadcast,
    input wire logic        frame_multicast,
    input wire logic        pause_detected
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [CNT_W-1:0] cnt_ff;
    logic [47:0]      dst_ff;
    logic [31:0]      ty_ff;
    logic [2:0]       ctrl_ff;
    wire              hit6 = rx_valid && !rx_sof && cnt_ff == 7'h05;
    wire              hit64 = rx_valid && !rx_sof && cnt_ff == 7'h3F;
    wire              short_end = rx_valid && rx_eof && (rx_sof || cnt_ff < 7'h3F);
    wire              bc = dst_ff == `BROADCAST_ADDR;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // The count saturates so a giant frame never aliases onto the byte 6 or byte 64 marks.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (rx_valid) begin
            cnt_ff <= rx_sof ? CNT_W'(1) : cnt_ff + CNT_W'(cnt_ff != '1);
        end
    end
    always_ff @(posedge mclk) begin
        if (rx_valid && (rx_sof || cnt_ff < 7'h06)) begin
            dst_ff <= {dst_ff[39:0], rx_data};
        end
    end
    always_ff @(posedge mclk) begin
        if (rx_valid && !rx_sof && cnt_ff >= 7'h0C && cnt_ff < 7'h10) begin
            ty_ff <= {ty_ff[23:0], rx_data};
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_ff <= 3'h0;
        end else if (avs_write && !avs_waitrequest && avs_address == `OFS_RECEIVE_CONTROL) begin
            ctrl_ff <= avs_writedata[2:0];
        end
    end

    sequence s_addr_done;
        hit6 ##2 1'b1;
    endsequence
    sequence s_frame_done;
        hit64 ##2 1'b1;
    endsequence

    a_accept_timing: assert property (fifo_accept |-> $past(hit64, 2))
        else $error("accept timing");
    a_reject_timing: assert property (fifo_reject |->
        $past(hit6, 2) || $past(hit64, 2) || $past(short_end, 2))
        else $error("reject timing");
    a_pause_rejects: assert property (pause_detected |-> fifo_reject && !fifo_accept)
        else $error("pause frame not rejected");
    a_pause_fields: assert property (pause_detected |-> ctrl_ff[2] && ty_ff == `PAUSE_TYPE_OP)
        else $error("pause without fields");
    a_addr_class: assert property (s_addr_done |->
        frame_broadcast == bc && frame_multicast == (dst_ff[40] && !bc))
        else $error("address class");
    a_bcast_accept: assert property (s_frame_done ##0 (bc && !ctrl_ff[0]) |-> fifo_accept && !frame_miss)
        else $error("broadcast not accepted");
    a_bcast_reject: assert property (s_addr_done ##0
        (bc && ctrl_ff[0] && !ctrl_ff[1]) |-> fifo_reject)
        else $error("broadcast not rejected");
    a_group_exact: assert property (s_addr_done ##0
        (dst_ff[40] && !bc && ctrl_ff == 3'h4 && dst_ff != `PAUSE_ADDR) |-> fifo_reject)
        else $error("group passed with flow control");
    a_miss_needs_promisc: assert property (fifo_accept && !ctrl_ff[1] |-> !frame_miss)
        else $error("miss without promiscuous");
    a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus wait");
endmodule

bind rx_address_filter rx_address_filter_assertions #(.CNT_W(CNT_W)) i_rx_address_filter_assertions (
    .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .rx_valid, .rx_data,
    .rx_sof, .rx_eof, .fifo_accept, .fifo_reject, .frame_miss, .frame_broadcast, .frame_multicast, .pause_detected
);

// File: verification/rx_frame_source.sv
module rx_frame_source (
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic                    start,
    input  wire logic                    slow,
    input  wire rx_filter_pkg::mac_addr_t dst,
    input  wire logic [31:0]             type_op,
    input  wire logic [7:0]              len,
    output logic                         busy,
    output logic                         rx_valid,
    output logic [7:0]                   rx_data,
    output logic                         rx_sof,
    output logic                         rx_eof
);
    timeunit 1ns;
    timeprecision 1ps;
    import rx_filter_pkg::*;
    logic [7:0] idx_ff;
    logic [7:0] nxt_data;

    always_comb begin
        if (idx_ff < 8'h06) nxt_data = dst[47 - 8 * idx_ff -: 8];
        else if (idx_ff >= 8'h0C && idx_ff < 8'h10) nxt_data = type_op[31 - 8 * (idx_ff - 8'h0C) -: 8];
        else nxt_data = idx_ff ^ 8'h5A;
    end

    // Outside a byte the data lines keep changing so that a stale byte is never read as fresh.
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy <= 1'b0;
            idx_ff <= 8'h00;
            {rx_valid, rx_sof, rx_eof, rx_data} <= 11'h000;
        end else if (busy && !(slow && $urandom_range(2) == 0)) begin
            {rx_valid, rx_sof, rx_eof} <= {1'b1, idx_ff == 8'h00, idx_ff == len - 8'h01};
            rx_data <= nxt_data;
            idx_ff <= idx_ff + 8'h01;
            busy <= idx_ff != len - 8'h01;
        end else begin
            {rx_valid, rx_sof, rx_eof} <= 3'h0;
            rx_data <= ~rx_data;
            if (start && !busy) begin
                busy <= 1'b1;
                idx_ff <= 8'h00;
            end
        end
    end
endmodule

// File: verification/rx_address_filter_tb_top.sv
`include "rx_address_filter_params.svh"

module rx_address_filter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rx_filter_pkg::*;

    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, rx_valid, rx_sof, rx_eof, p_busy;
    logic [7:0]  rx_data;
    logic        fifo_accept, fifo_reject, frame_miss, frame_broadcast, frame_multicast, pause_detected;
    logic        p_start = 1'b0;
    logic        p_slow = 1'b0;
    mac_addr_t   p_dst = '0;
    mac_addr_t   sta;
    logic [31:0] p_ty = '0;
    logic [7:0]  p_len = 8'h40;
    logic [2:0]  ctrl;
    logic [31:0] gu, gl, uu, ul;
    int          err_count = 0;
    int          total_checks = 0;

    always #2.5 mclk = ~mclk;

    rx_address_filter #(.CNT_W(7)) i_rx_address_filter (
        .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .rx_valid, .rx_data, .rx_sof, .rx_eof, .fifo_accept, .fifo_reject, .frame_miss, .frame_broadcast,
        .frame_multicast, .pause_detected
    );
    rx_frame_source i_rx_frame_source (
        .mclk, .rst, .start(p_start), .slow(p_slow), .dst(p_dst), .type_op(p_ty), .len(p_len), .busy(p_busy),
        .rx_valid, .rx_data, .rx_sof, .rx_eof
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            err_count++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, want);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, !wr};
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
        @(posedge mclk);
    endtask

    function automatic hash_index_t hash_of(input mac_addr_t dst);
        logic [31:0] c;
        c = `CRC_PRESET;
        for (int i = 0; i < 48; i++) begin
            c = {c[30:0], 1'b0} ^ ((c[31] ^ dst[40 - 8 * (i / 8) + i % 8]) ? `CRC_POLY : 32'h0);
        end
        return c[31:26];
    endfunction

    function automatic logic [2:0] expect_of(input mac_addr_t dst, input logic [31:0] ty, input int len);
        hash_index_t h;
        logic        hit;
        h = hash_of(dst);
        if (dst == `BROADCAST_ADDR) hit = !ctrl[0];
        else if (dst[40]) begin
            hit = ctrl[2] ? dst == `PAUSE_ADDR : (h[5] ? gu[h[4:0]] : gl[h[4:0]]);
        end
        else hit = dst == sta || (h[5] ? uu[h[4:0]] : ul[h[4:0]]);
        if ((!hit && !ctrl[1]) || len < 64) return 3'b000;
        if (ctrl[2] && (dst == `PAUSE_ADDR || dst == sta) && ty == `PAUSE_TYPE_OP) begin
            return 3'b001;
        end
        return {1'b1, !hit, 1'b0};
    endfunction

    task automatic frame(input mac_addr_t dst, input logic [31:0] ty, input int len);
        logic [31:0] want;
        logic [31:0] seen;
        logic [2:0]  e;
        int          n;
        e = expect_of(dst, ty, len);
        want = 32'({!e[2], e, dst == `BROADCAST_ADDR, dst[40] && dst != `BROADCAST_ADDR});
        {p_dst, p_ty, p_len, p_slow, p_start} <= {dst, ty, 8'(len), 1'($urandom), 1'b1};
        @(posedge mclk);
        p_start <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (fifo_accept !== 1'b1 && fifo_reject !== 1'b1 && n < 400);
        seen = 32'({fifo_reject, fifo_accept, fifo_accept & frame_miss, pause_detected, frame_broadcast,
                    frame_multicast});
        check(seen, want);
        while (p_busy) @(posedge mclk);
        repeat (3) @(posedge mclk);
        bus(1'b0, `OFS_FILTER_STATUS, 32'h0000_0000, seen);
        check(32'(seen[5:0]), 32'(hash_of(dst)));
    endtask

    task automatic results();
        $display("Checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        results();
    end

    initial begin
        logic [31:0] q;
        void'($urandom(59723));
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int a = 0; a < 8; a++) begin
            bus(1'b0, 5'(4 * a), 32'h0000_0000, q);
            check(q, `REG_RESET);
        end
        bus(1'b1, 5'h01, 32'hFFFF_FFFF, q);
        bus(1'b0, 5'h01, 32'h0000_0000, q);
        check(q, 32'h0000_0000);
        bus(1'b0, `OFS_RECEIVE_CONTROL, 32'h0000_0000, q);
        check(q, 32'h0000_0000);
        for (int m = 0; m < 8; m++) begin
            ctrl = 3'(m);
            sta = {16'($urandom), $urandom} & 48'hFEFF_FFFF_FFFF;
            {gu, gl, uu, ul} = {$urandom, $urandom, $urandom, $urandom};
            bus(1'b1, `OFS_RECEIVE_CONTROL, {29'h0, ctrl}, q);
            bus(1'b1, `OFS_STATION_ADDR_LOW, sta[47:16], q);
            bus(1'b1, `OFS_STATION_ADDR_HIGH, {sta[15:0], 16'h0000}, q);
            bus(1'b1, `OFS_GROUP_HASH_UPPER, gu, q);
            bus(1'b1, `OFS_GROUP_HASH_LOWER, gl, q);
            bus(1'b1, `OFS_UNICAST_HASH_UPPER, uu, q);
            bus(1'b1, `OFS_UNICAST_HASH_LOWER, ul, q);
            bus(1'b0, `OFS_STATION_ADDR_HIGH, 32'h0000_0000, q);
            check(q, {sta[15:0], 16'h0000});
            frame(`BROADCAST_ADDR, $urandom, 64 + $urandom_range(8));
            frame(sta, `PAUSE_TYPE_OP, 64);
            frame(`PAUSE_ADDR, `PAUSE_TYPE_OP, 72);
            frame(`PAUSE_ADDR, 32'h0800_0000, 64);
            for (int k = 0; k < 5; k++) begin
                frame({16'($urandom), $urandom}, $urandom, k == 4 ? 20 : 64 + $urandom_range(16));
            end
        end
        results();
    end
endmodule
